// >>> rtl/muxed_port_defs.vh
// Constants for the multiplexed host port of the clock device.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef MUXED_PORT_DEFS_VH
`define MUXED_PORT_DEFS_VH
`define ADDR_RESET 8'h00
`define DATA_RESET 8'h00
`define RESET_MIN_MS 200
`define STATUS_REG_ADDR 8'h0C
`define CTRL_REG_ADDR 8'h0B
`define CTRL_PERIODIC_EN_BIT 6
`define CTRL_ALARM_EN_BIT 5
`define CTRL_UPDATE_EN_BIT 4
`define CTRL_SQUARE_EN_BIT 3
`define STAT_SUMMARY_BIT 7
`define STAT_PERIODIC_BIT 6
`define STAT_ALARM_BIT 5
`define STAT_UPDATE_BIT 4
`define SYNC_WARM 2'h3
`endif

// >>> rtl/pin_sync.v
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes one clock domain; first stage is read only by the second.
`default_nettype none
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rstn,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync_out
);
  reg [WIDTH-1:0] meta;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= {WIDTH{1'b0}};
      pin_sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= pin_in;
      pin_sync_out <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> rtl/muxed_bus_port.v
// Host port of a real-time clock: multiplexed address/data bus, two timing
// styles, reset effects on interrupt bits and the open-drain request output.
// Assumes all pins are asynchronous to sys_clk; timekeeping lives elsewhere.
`default_nettype none
`include "muxed_port_defs.vh"
module muxed_bus_port (
  input wire sys_clk,
  input wire rstn,
  input wire timing_style_strap,
  input wire addr_strobe,
  input wire data_strobe_or_read_en,
  input wire rw_dir,
  input wire chip_sel_n,
  input wire reset_pin_n,
  input wire [7:0] ad_in,
  output reg [7:0] ad_out,
  output reg ad_oe,
  output reg irq_n_out,
  output reg irq_n_oe,
  input wire periodic_event,
  input wire alarm_event,
  input wire update_event,
  input wire [7:0] reg_rd_data,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wr_data,
  output reg reg_wr,
  output reg reg_rd,
  output reg periodic_int_en,
  output reg alarm_int_en,
  output reg update_end_int_en,
  output reg square_wave_out_en,
  output reg alarm_int_flag,
  output reg update_end_flag,
  output reg periodic_flag,
  output reg int_summary_flag,
  output reg strobe_style
);
  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function is_status;
    input [7:0] addr;
    begin
      is_status = (addr == `STATUS_REG_ADDR);
    end
  endfunction

  function is_ctrl;
    input [7:0] addr;
    begin
      is_ctrl = (addr == `CTRL_REG_ADDR);
    end
  endfunction

  function [7:0] status_byte;
    input summary;
    input periodic;
    input alarm;
    input update;
    begin
      status_byte = 8'h00;
      status_byte[`STAT_SUMMARY_BIT] = summary;
      status_byte[`STAT_PERIODIC_BIT] = periodic;
      status_byte[`STAT_ALARM_BIT] = alarm;
      status_byte[`STAT_UPDATE_BIT] = update;
    end
  endfunction

  function [7:0] ctrl_byte;
    input periodic;
    input alarm;
    input update;
    input square;
    begin
      ctrl_byte = 8'h00;
      ctrl_byte[`CTRL_PERIODIC_EN_BIT] = periodic;
      ctrl_byte[`CTRL_ALARM_EN_BIT] = alarm;
      ctrl_byte[`CTRL_UPDATE_EN_BIT] = update;
      ctrl_byte[`CTRL_SQUARE_EN_BIT] = square;
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [13:0] sync_bus;
  pin_sync #(.WIDTH(14)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in({timing_style_strap, addr_strobe, data_strobe_or_read_en, rw_dir, chip_sel_n, reset_pin_n, ad_in}),
    .pin_sync_out(sync_bus)
  );
  wire s_strap = sync_bus[13];
  wire s_astb = sync_bus[12];
  wire s_dstb = sync_bus[11];
  wire s_rw = sync_bus[10];
  wire s_cs_n = sync_bus[9];
  wire s_rst_n = sync_bus[8];
  wire [7:0] s_ad = sync_bus[7:0];

  // ----------------------------------------
  // Warm-up after reset
  // ----------------------------------------
  // Synchronisers come out of reset low, not at the pins' idle levels;
  // edges are ignored until both stages and the history hold real pin values
  reg [1:0] warm;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warm <= 2'h0;
    end else if (warm != `SYNC_WARM) begin
      warm <= warm + 2'h1;
    end
  end
  wire edges_ok = (warm == `SYNC_WARM);

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  reg astb_d;
  reg dstb_d;
  reg rw_d;
  reg addr_valid;
  // Data sampled one cycle behind so write data lines up with the delayed edge
  reg [7:0] ad_d;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      astb_d <= 1'b0;
      dstb_d <= 1'b0;
      rw_d <= 1'b1;
      ad_d <= `DATA_RESET;
    end else begin
      astb_d <= s_astb;
      dstb_d <= s_dstb;
      rw_d <= s_rw;
      ad_d <= s_ad;
    end
  end
  wire astb_fall = edges_ok & astb_d & ~s_astb;
  wire astb_rise = edges_ok & ~astb_d & s_astb;
  wire dstb_fall = edges_ok & dstb_d & ~s_dstb;
  wire dstb_rise = edges_ok & ~dstb_d & s_dstb;
  wire rw_rise = edges_ok & ~rw_d & s_rw;
  wire port_ok = edges_ok & s_rst_n & ~s_cs_n & addr_valid;

  // ----------------------------------------
  // Timing style, address latch
  // ----------------------------------------
  // Strap is sampled continuously; a strap is static in practice
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_style <= 1'b0;
      reg_addr <= `ADDR_RESET;
      addr_valid <= 1'b0;
    end else begin
      strobe_style <= s_strap;
      if (astb_fall) begin
        reg_addr <= ad_d;
        addr_valid <= 1'b1;
      end else if (astb_rise) begin
        reg_addr <= `ADDR_RESET;
        addr_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read and write decoding
  // ----------------------------------------
  // Strobe style: read while strobe and direction high; write at strobe fall
  // Enable style: read while enable low with direction high; write at rw rise
  wire read_active = strobe_style ? (s_dstb & s_rw) : (~s_dstb & s_rw);
  wire write_take = strobe_style ? (dstb_fall & ~rw_d) : rw_rise;
  wire read_end = strobe_style ? dstb_fall : dstb_rise;
  reg read_seen;
  wire status_read_done = read_end & read_seen & is_status(reg_addr);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ad_out <= `DATA_RESET;
      ad_oe <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wr_data <= `DATA_RESET;
      read_seen <= 1'b0;
    end else begin
      reg_wr <= port_ok & write_take;
      reg_rd <= port_ok & read_active & ~read_seen;
      if (port_ok & write_take) begin
        reg_wr_data <= ad_d;
      end
      if (port_ok & read_active & ~read_end) begin
        ad_oe <= 1'b1;
        read_seen <= 1'b1;
        if (is_status(reg_addr)) begin
          ad_out <= status_byte(int_summary_flag, periodic_flag, alarm_int_flag, update_end_flag);
        end else if (is_ctrl(reg_addr)) begin
          ad_out <= ctrl_byte(periodic_int_en, alarm_int_en, update_end_int_en, square_wave_out_en);
        end else begin
          ad_out <= reg_rd_data;
        end
      end else begin
        ad_oe <= 1'b0;
        if (read_end | ~port_ok) begin
          read_seen <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt enables and flags
  // ----------------------------------------
  // Only interrupt state and the square-wave enable live here; time, calendar and RAM are untouched
  wire ctrl_wr = port_ok & write_take & is_ctrl(reg_addr);
  wire [2:0] pend = {periodic_flag & periodic_int_en, alarm_int_flag & alarm_int_en,
                     update_end_flag & update_end_int_en};

  // Enables: host writes, the reset pin forces them off
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      periodic_int_en <= 1'b0;
      alarm_int_en <= 1'b0;
      update_end_int_en <= 1'b0;
      square_wave_out_en <= 1'b0;
    end else if (!s_rst_n) begin
      periodic_int_en <= 1'b0;
      alarm_int_en <= 1'b0;
      update_end_int_en <= 1'b0;
      square_wave_out_en <= 1'b0;
    end else if (ctrl_wr) begin
      periodic_int_en <= ad_d[`CTRL_PERIODIC_EN_BIT];
      alarm_int_en <= ad_d[`CTRL_ALARM_EN_BIT];
      update_end_int_en <= ad_d[`CTRL_UPDATE_EN_BIT];
      square_wave_out_en <= ad_d[`CTRL_SQUARE_EN_BIT];
    end
  end

  // Periodic flag is not among those the reset pin clears, so it keeps latching events
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      periodic_flag <= 1'b0;
    end else begin
      periodic_flag <= periodic_event | (periodic_flag & ~status_read_done);
    end
  end

  // New events win over a clearing status read in the same cycle
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_int_flag <= 1'b0;
      update_end_flag <= 1'b0;
      int_summary_flag <= 1'b0;
    end else if (!s_rst_n) begin
      alarm_int_flag <= 1'b0;
      update_end_flag <= 1'b0;
      int_summary_flag <= 1'b0;
    end else begin
      alarm_int_flag <= alarm_event | (alarm_int_flag & ~status_read_done);
      update_end_flag <= update_event | (update_end_flag & ~status_read_done);
      int_summary_flag <= (|pend) | (int_summary_flag & ~status_read_done);
    end
  end

  // ----------------------------------------
  // Open-drain request
  // ----------------------------------------
  // The pin level is only ever low; the enable decides whether it is pulled
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_oe <= 1'b0;
      irq_n_out <= 1'b0;
    end else if (!s_rst_n) begin
      irq_n_oe <= 1'b0;
      irq_n_out <= 1'b0;
    end else begin
      irq_n_oe <= |pend;
      irq_n_out <= 1'b0;
    end
  end
endmodule // muxed_bus_port
`default_nettype wire

// >>> bench/host_bus_model.sv
// Host model: one multiplexed bus access per call of acc.
// Assumes the bench resolves the shared bus from the port's drive.
`default_nettype none
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] bus,
  output logic astb_o,
  output logic dstb_o,
  output logic rw_o,
  output logic cs_n_o,
  output logic [7:0] ad_o
);
  initial {astb_o, dstb_o, rw_o, cs_n_o, ad_o} = 12'h300;
  task automatic acc(input bit s, c, w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    cs_n_o = c;
    dstb_o = !s;
    rw_o = !(s && w);
    astb_o = 1;
    ad_o = a;
    repeat (6) @(negedge clk);
    astb_o = 0;
    repeat (5) @(negedge clk);
    // Released bus shows the inverse, so a stale value never passes
    ad_o = w ? d : ~a;
    if (s) dstb_o = 1;
    else if (w) rw_o = 0;
    else dstb_o = 0;
    repeat (8) @(negedge clk);
    q = bus;
    if (s) dstb_o = 0;
    else if (w) rw_o = 1;
    else dstb_o = 1;
    repeat (6) @(negedge clk);
    rw_o = 1;
    cs_n_o = 1;
  endtask
endmodule // host_bus_model
`default_nettype wire

// >>> bench/muxed_bus_port_sva.sv
// Checker for the host port: address latch, reset pin and request timing.
// Assumes pins hold each level six cycles or more.
`default_nettype none
module muxed_bus_port_sva (
  input wire logic sys_clk, rstn, reset_pin_n, addr_strobe, data_strobe_or_read_en, chip_sel_n,
  input wire logic [7:0] ad_in, reg_addr,
  input wire logic ad_oe, irq_n_oe, reg_wr, strobe_style, periodic_flag, int_summary_flag,
  input wire logic periodic_int_en, alarm_int_en, update_end_int_en, square_wave_out_en,
  input wire logic alarm_int_flag, update_end_flag
);
  // ------
  // Checks
  // ------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_addr; $fell(addr_strobe) && reset_pin_n |-> ##5 reg_addr == $past(ad_in, 5); endproperty
  a_addr: assert property (p_addr) else $error("address not latched");
  property p_clr; $rose(addr_strobe) && reset_pin_n |-> ##5 reg_addr == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("address not cleared");
  property p_en; !reset_pin_n [*4] |-> !(periodic_int_en | alarm_int_en | update_end_int_en | square_wave_out_en); endproperty
  a_en: assert property (p_en) else $error("enable kept in reset");
  property p_flag; !reset_pin_n [*4] |-> !(alarm_int_flag | update_end_flag | int_summary_flag); endproperty
  a_flag: assert property (p_flag) else $error("flag kept in reset");
  property p_hold; !reset_pin_n [*4] |-> !(irq_n_oe | ad_oe | reg_wr); endproperty
  a_hold: assert property (p_hold) else $error("activity in reset");
  // Reset pin lags by the synchroniser, so the follow check stands aside then
  property p_fol; disable iff (!rstn || !reset_pin_n) alarm_int_flag && alarm_int_en ||
    update_end_flag && update_end_int_en || periodic_flag && periodic_int_en |=> irq_n_oe; endproperty
  a_fol: assert property (p_fol) else $error("request not driven");
  property p_rel; (strobe_style ? !data_strobe_or_read_en : data_strobe_or_read_en) [*7] |-> !ad_oe; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_cs; chip_sel_n [*7] |-> !(reg_wr | ad_oe); endproperty
  a_cs: assert property (p_cs) else $error("access while deselected");
  c_wr: cover property (reg_wr);
  c_rd: cover property (ad_oe);
  c_irq: cover property (irq_n_oe);
endmodule // muxed_bus_port_sva
bind muxed_bus_port muxed_bus_port_sva chk (.sys_clk, .rstn, .reset_pin_n, .addr_strobe, .data_strobe_or_read_en,
  .chip_sel_n, .ad_in, .reg_addr, .ad_oe, .irq_n_oe, .reg_wr, .strobe_style, .periodic_flag, .int_summary_flag,
  .periodic_int_en, .alarm_int_en, .update_end_int_en, .square_wave_out_en, .alarm_int_flag, .update_end_flag);
`default_nettype wire

// >>> bench/muxed_bus_port_tb.sv
// Bench for the host port: both timing styles, interrupt and reset pin.
// Assumes host_bus_model and the bound checker.
`default_nettype none
module muxed_bus_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
  logic sys_clk = 0, rstn = 0, strap = 1, rpn = 1, pe = 0, ae = 0, ue = 0;
  logic [7:0] rdd = 8'h00, v, q, wa, wd, ad_out, hd;
  logic ad_oe, irq_n_oe, irq_n_out, astb, dstb, rw, cs_n, reg_wr, en_p, en_a, en_u, en_sq, fl_a, fl_u, fl_sum;
  int fail_count = 0, compares = 0, cyc = 0, nwr = 0, ctl = 0, k;
  // Model of accepted writes: queued by the host side, popped at each write pulse
  int wq[$];
  wire [7:0] ad_bus = ad_oe ? ad_out : hd;
  host_bus_model h (.clk(sys_clk), .bus(ad_bus), .astb_o(astb), .dstb_o(dstb), .rw_o(rw), .cs_n_o(cs_n), .ad_o(hd));
  muxed_bus_port uut (.sys_clk, .rstn, .timing_style_strap(strap), .addr_strobe(astb), .data_strobe_or_read_en(dstb),
    .rw_dir(rw), .chip_sel_n(cs_n), .reset_pin_n(rpn), .ad_in(ad_bus), .ad_out, .ad_oe, .irq_n_out, .irq_n_oe,
    .periodic_event(pe), .alarm_event(ae), .update_event(ue), .reg_rd_data(rdd), .reg_addr(wa), .reg_wr_data(wd),
    .reg_wr, .reg_rd(), .periodic_int_en(en_p), .alarm_int_en(en_a), .update_end_int_en(en_u),
    .square_wave_out_en(en_sq), .alarm_int_flag(fl_a), .update_end_flag(fl_u), .periodic_flag(),
    .int_summary_flag(fl_sum), .strobe_style());
  initial forever #4 sys_clk = ~sys_clk;
  // Ceiling is several times the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (reg_wr === 1'b1) begin
      nwr++;
      `CHK(wd, (wq.size() > 0) ? 8'(wq[0]) : ~wd)
      if (wq.size() > 0) void'(wq.pop_front());
    end
    if (cyc == 4000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    v = 8'($urandom(26030));
    repeat (5) @(negedge sys_clk);
    rstn = 1;
    for (int s = 1; s >= 0; s--) begin
      strap = s[0];
      repeat (4) @(negedge sys_clk);
      v = 8'($urandom);
      rdd = 8'($urandom);
      ctl = v;
      wq.push_back(v);
      h.acc(s[0], 0, 1, 8'h0B, v, q);
      `CHK({en_p, en_a, en_u, en_sq}, ctl[6:3])
      wq.push_back(~v);
      h.acc(s[0], 0, 1, 8'h21, ~v, q);
      `CHK({wa, wd}, {8'h21, ~v})
      h.acc(s[0], 0, 0, 8'h47, 8'h00, q);
      `CHK(q, rdd)
      h.acc(s[0], 1, 1, 8'h0B, ~v, q);
      `CHK({wa, en_p, en_a, en_u, en_sq}, {8'h0B, ctl[6:3]})
      $display("style %0d done", s);
    end
    wq.push_back(8'h20);
    h.acc(0, 0, 1, 8'h0B, 8'h20, q);
    ae = 1;
    @(negedge sys_clk);
    ae = 0;
    repeat (3) @(negedge sys_clk);
    `CHK({irq_n_oe, irq_n_out, fl_a, fl_sum}, 4'b1011)
    h.acc(0, 0, 0, 8'h0C, 8'h00, q);
    `CHK({q, irq_n_oe, fl_a}, {8'hA0, 2'b00})
    wq.push_back(8'h78);
    h.acc(0, 0, 1, 8'h0B, 8'h78, q);
    ue = 1;
    @(negedge sys_clk);
    ue = 0;
    rpn = 0;
    repeat (4) @(negedge sys_clk);
    `CHK({en_p, en_a, en_u, en_sq, fl_u, fl_sum, irq_n_oe}, 7'h00)
    k = nwr;
    h.acc(0, 0, 1, 8'h21, 8'h55, q);
    `CHK(nwr, k)
    `CHK(wq.size(), 0)
    rpn = 1;
    $display("interrupt and reset done");
    results();
  end
endmodule // muxed_bus_port_tb
`default_nettype wire
